// [src/jps_pkg.sv]
package jps_pkg;

   localparam int unsigned ADDR_W = 5;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned MAG_W  = 6;

   localparam logic [4:0] ADDR_ATTEN_CTRL  = 5'h18;
   localparam logic [4:0] ADDR_EQ_CTRL     = 5'h19;
   localparam logic [4:0] ADDR_SHAPE_FIRST = 5'h1C;
   localparam logic [4:0] ADDR_SHAPE_SECOND = 5'h1D;
   localparam logic [4:0] ADDR_SHAPE_THIRD = 5'h1E;
   localparam logic [4:0] ADDR_SHAPE_FOURTH = 5'h1F;

   // Field positions
   localparam int unsigned ATTEN_DEPTH_LSB = 2;
   localparam int unsigned ATTEN_CLEAR_BIT = 1;
   localparam int unsigned EQ_DISABLE_BIT  = 7;
   localparam int unsigned EQ_ONE_BIT      = 6;
   localparam int unsigned EQ_TWO_BIT      = 5;
   localparam int unsigned SHAPE_SIGN_BIT  = 6;

   // Writable bits; all else reads zero
   localparam logic [7:0] ATTEN_MASK = 8'h1E;
   localparam logic [7:0] EQ_MASK    = 8'hE0;
   localparam logic [7:0] SHAPE_MASK = 8'h7F;
   localparam logic [7:0] RESET_VAL  = 8'h00;

   localparam logic [7:0] ATTEN_DEPTH_STEP = 8'h10;
   localparam int unsigned SHAPE_SLOTS = 4;

   typedef enum logic [1:0] {
      JPS_EQ_AUTO = 2'b00,
      JPS_EQ_FLAT = 2'b01,
      JPS_EQ_ONE  = 2'b10,
      JPS_EQ_TWO  = 2'b11
   } jps_eq_mode_type;

   typedef struct packed {
      logic             sign;
      logic [MAG_W-1:0] mag;
   } jps_shape_level_type;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } jps_host_req_type;

endpackage

// [src/jps_ctrl_regs.sv]
// Notes on behaviour
// - Depth field gives 16 times (code+1) words
// - Clear bit resets attenuator pointers and status
// - Clear leaves stored FIFO data untouched
// - Auto-disable zero runs automatic equalizer
// - Disabled with one-stage bit picks 6 dB
// - Else two-stage bit picks 12 dB
// - First level magnitude in bits 5..0
// - Bit 6 is sign, one means positive
// - Second level coefficient for second quarter
// - Third level coefficient for third quarter
// - Fourth level coefficient for final quarter
`timescale 1ns/1ps
`default_nettype none

module jps_ctrl_regs (
   input  wire logic                        i_sys_clk,
   input  wire logic                        i_resetn,
   input  wire jps_pkg::jps_host_req_type   i_host_req,
   output logic [jps_pkg::DATA_W-1:0]       o_rdata,
   output logic [7:0]                       o_atten_depth_words,
   output logic                             o_atten_clear,
   output jps_pkg::jps_eq_mode_type         o_eq_mode,
   output jps_pkg::jps_shape_level_type     o_shape_first,
   output jps_pkg::jps_shape_level_type     o_shape_second,
   output jps_pkg::jps_shape_level_type     o_shape_third,
   output jps_pkg::jps_shape_level_type     o_shape_fourth
);
   import jps_pkg::*;

   logic                      rst_meta_q;
   logic                      rst_sync_q;
   logic [DATA_W-1:0]         atten_q;
   logic [DATA_W-1:0]         atten_d;
   logic [DATA_W-1:0]         eq_q;
   logic [DATA_W-1:0]         eq_d;
   logic [DATA_W-1:0]         shape_q [SHAPE_SLOTS];
   logic [DATA_W-1:0]         shape_d [SHAPE_SLOTS];
   logic [DATA_W-1:0]         rdata_q;
   logic [DATA_W-1:0]         rdata_d;
   logic [2:0]                depth_code;
   logic [7:0]                depth_words_q;
   jps_eq_mode_type           eq_mode_q;
   logic                      wr_atten;
   logic                      wr_eq;
   logic [SHAPE_SLOTS-1:0]    wr_shape;

   // Slot index to register address
   function automatic logic [4:0] shape_addr(input int unsigned idx);
      case (idx)
         0: shape_addr = ADDR_SHAPE_FIRST;
         1: shape_addr = ADDR_SHAPE_SECOND;
         2: shape_addr = ADDR_SHAPE_THIRD;
         default: shape_addr = ADDR_SHAPE_FOURTH;
      endcase
   endfunction

   // Write strobe for one address
   function automatic logic hit(input jps_host_req_type r,
                                input logic [4:0]       a);
      hit = r.wr && (r.addr == a);
   endfunction

   // Depth in words: one step per code count, plus one step
   function automatic logic [7:0] depth_of(input logic [2:0] code);
      depth_of = ATTEN_DEPTH_STEP * ({5'h00, code} + 8'h01);
   endfunction

   // One-stage outranks two-stage; neither leaves the path flat
   function automatic jps_eq_mode_type eq_decode(input logic [7:0] ctrl);
      if (!ctrl[EQ_DISABLE_BIT]) begin
         eq_decode = JPS_EQ_AUTO;
      end else if (ctrl[EQ_ONE_BIT]) begin
         eq_decode = JPS_EQ_ONE;
      end else if (ctrl[EQ_TWO_BIT]) begin
         eq_decode = JPS_EQ_TWO;
      end else begin
         eq_decode = JPS_EQ_FLAT;
      end
   endfunction

   // Sign in bit 6, magnitude MSB in bit 5
   function automatic jps_shape_level_type level_of(input logic [7:0] b);
      level_of = '{sign: b[SHAPE_SIGN_BIT], mag: b[MAG_W-1:0]};
   endfunction

   // Reset asserts at once but is released through two flops,
   // so no register leaves reset on an edge near the release
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // Write strobes, one per register
   assign wr_atten = hit(i_host_req, ADDR_ATTEN_CTRL);
   assign wr_eq    = hit(i_host_req, ADDR_EQ_CTRL);

   // Next values; masks keep unused bits at zero
   always_comb begin
      atten_d = atten_q;
      if (wr_atten) begin
         atten_d = i_host_req.wdata & ATTEN_MASK;
      end
   end

   always_comb begin
      eq_d = eq_q;
      if (wr_eq) begin
         eq_d = i_host_req.wdata & EQ_MASK;
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         atten_q <= RESET_VAL;
      end else begin
         atten_q <= atten_d;
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         eq_q <= RESET_VAL;
      end else begin
         eq_q <= eq_d;
      end
   end

   // One register per quarter of the bit cell
   genvar g;
   generate
      for (g = 0; g < SHAPE_SLOTS; g++) begin : g_shape
         assign wr_shape[g] = hit(i_host_req, shape_addr(g));

         always_comb begin
            shape_d[g] = shape_q[g];
            if (wr_shape[g]) begin
               shape_d[g] = i_host_req.wdata & SHAPE_MASK;
            end
         end

         always_ff @(posedge i_sys_clk or negedge rst_sync_q) begin
            if (!rst_sync_q) begin
               shape_q[g] <= RESET_VAL;
            end else begin
               shape_q[g] <= shape_d[g];
            end
         end
      end
   endgenerate

   // Derived outputs load from the next values, so they move on the
   // same edge as their control byte rather than one cycle later;
   // the cost is one decode in front of each of their flops
   assign depth_code = atten_d[ATTEN_DEPTH_LSB +: 3];

   always_ff @(posedge i_sys_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         depth_words_q <= ATTEN_DEPTH_STEP;
      end else begin
         depth_words_q <= depth_of(depth_code);
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         eq_mode_q <= JPS_EQ_AUTO;
      end else begin
         eq_mode_q <= eq_decode(eq_d);
      end
   end

   // Depth leaves from a flop
   assign o_atten_depth_words = depth_words_q;

   // Held while the bit is one; the FIFO owner resets pointers and
   // status only, storage has no reset path so old words survive.
   assign o_atten_clear = atten_q[ATTEN_CLEAR_BIT];

   // Decoded mode leaves from a flop
   assign o_eq_mode = eq_mode_q;

   // One coefficient per quarter of the bit cell
   assign o_shape_first  = level_of(shape_q[0]);
   assign o_shape_second = level_of(shape_q[1]);
   assign o_shape_third  = level_of(shape_q[2]);
   assign o_shape_fourth = level_of(shape_q[3]);

   // Gaps and unmapped addresses read zero; a read in the same
   // cycle as a write returns the old byte
   always_comb begin
      rdata_d = rdata_q;
      if (i_host_req.rd) begin
         case (i_host_req.addr)
            ADDR_ATTEN_CTRL:   rdata_d = atten_q;
            ADDR_EQ_CTRL:      rdata_d = eq_q;
            ADDR_SHAPE_FIRST:  rdata_d = shape_q[0];
            ADDR_SHAPE_SECOND: rdata_d = shape_q[1];
            ADDR_SHAPE_THIRD:  rdata_d = shape_q[2];
            ADDR_SHAPE_FOURTH: rdata_d = shape_q[3];
            default:           rdata_d = RESET_VAL;
         endcase
      end
   end

   // Read data held until the next read
   always_ff @(posedge i_sys_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         rdata_q <= RESET_VAL;
      end else begin
         rdata_q <= rdata_d;
      end
   end
   assign o_rdata = rdata_q;

endmodule

`default_nettype wire

// [test/jps_ctrl_regs_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module jps_ctrl_regs_monitor import jps_pkg::*; (
   input wire logic                i_sys_clk,
   input wire logic                i_resetn,
   input wire jps_host_req_type    i_host_req,
   input wire logic [7:0]          o_rdata,
   input wire logic [7:0]          o_atten_depth_words,
   input wire logic                o_atten_clear,
   input wire jps_eq_mode_type     o_eq_mode,
   input wire jps_shape_level_type o_shape_third
);
   wire jps_host_req_type q = i_host_req;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   function automatic logic we(jps_host_req_type r, int a);
      return r.wr && r.addr == a;
   endfunction
   a_depth_map: assert property (we(q, 24) |=>
      o_atten_depth_words == {$past(q.wdata[4:2]), 4'h0} + 8'h10)
      else $error("depth");
   a_clear_level: assert property (we(q, 24) |=>
      o_atten_clear == $past(q.wdata[1])) else $error("clear");
   a_clear_hold: assert property (!we(q, 24) |=> $stable(o_atten_clear))
      else $error("clear moved");
   a_eq_auto: assert property (we(q, 25) && !q.wdata[7]
      |=> o_eq_mode == JPS_EQ_AUTO) else $error("eq auto");
   a_eq_one: assert property (we(q, 25) && &q.wdata[7:6]
      |=> o_eq_mode == JPS_EQ_ONE) else $error("eq one");
   a_eq_two: assert property (we(q, 25) && q.wdata[7:5] == 5
      |=> o_eq_mode == JPS_EQ_TWO) else $error("eq two");
   a_shape_third: assert property (we(q, 30)
      |=> o_shape_third == $past(q.wdata[6:0])) else $error("third");
   a_read_gap: assert property (q.rd && q.addr == 26
      |=> o_rdata == 8'h00) else $error("gap read");
   c_eq: cover property (we(q, 25));
   c_clear: cover property (o_atten_clear);
   c_read: cover property (q.rd);
endmodule
bind jps_ctrl_regs jps_ctrl_regs_monitor MON (.i_sys_clk(i_sys_clk),
   .i_resetn(i_resetn), .i_host_req(i_host_req), .o_rdata(o_rdata),
   .o_atten_depth_words(o_atten_depth_words),
   .o_atten_clear(o_atten_clear), .o_eq_mode(o_eq_mode),
   .o_shape_third(o_shape_third));
`default_nettype wire

// [test/jps_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module jps_host_model (
   input  wire logic                     i_sys_clk,
   output var jps_pkg::jps_host_req_type o_req
);
   initial o_req = '0;
   // Idle cycle after each access keeps strobes one cycle wide
   task automatic access(input logic w, input logic [12:0] ad);
      o_req <= {w, !w, ad};
      @(posedge i_sys_clk);
      o_req <= '0;
      @(posedge i_sys_clk);
   endtask
endmodule
`default_nettype wire

// [test/jps_ctrl_regs_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module jps_ctrl_regs_bench;
   import jps_pkg::*;
   logic clk = 0, rn = 0, c;
   logic [7:0] rd, dw;
   jps_host_req_type q;
   jps_eq_mode_type md;
   jps_shape_level_type s[4];
   int fail_count = 0, checked = 0, cyc = 0, m[32];
   logic [31:0] x = 32'h1E7E;
   always #50 clk = ~clk;
   jps_host_model HOST (.i_sys_clk(clk), .o_req(q));
   jps_ctrl_regs DUT (.i_sys_clk(clk), .i_resetn(rn), .i_host_req(q),
      .o_rdata(rd), .o_atten_depth_words(dw), .o_atten_clear(c),
      .o_eq_mode(md), .o_shape_first(s[0]), .o_shape_second(s[1]),
      .o_shape_third(s[2]), .o_shape_fourth(s[3]));
   function automatic logic [31:0] nx();
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic chk(input logic [7:0] g, e);
      checked++;
      if (g !== e)
         $display("[ERR] %0t got %h want %h", $time, g, e);
      fail_count += int'(g !== e);
   endtask
   task automatic give_verdict();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Write, check every output against the model, then read back
   task automatic put(input logic [4:0] a, input logic [7:0] d);
      HOST.access(1, {a, d});
      m[a] = d & (a == 24 ? 8'h1E : a == 25 ? 8'hE0 : a > 27 ? 8'h7F : 8'h0);
      chk(dw, 8'(m[24] / 4 % 8 * 16 + 16));
      chk({7'h0, c}, 8'(m[24] / 2 % 2));
      chk({6'h0, md}, 8'(m[25] < 128 ? 0 : m[25] > 191 ? 2 : m[25] > 159 ? 3 : 1));
      for (int i = 0; i < 4; i++)
         chk({1'b0, s[i]}, 8'(m[28 + i]));
      HOST.access(0, {a, 8'h00});
      chk(rd, 8'(m[a]));
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rn <= 1;
      repeat (3) @(posedge clk);
      for (int k = 0; k < 8; k++)
         put(5'h19, 8'(k * 32));
      repeat (40)
         put(5'(24 + nx() % 8), 8'(nx()));
      give_verdict();
   end
   always @(posedge clk)
      if (++cyc > 1000) begin
         fail_count++;
         give_verdict();
      end
endmodule
`default_nettype wire
